/* common/tgcr_pkg.sv */
// package of constants and types for the timing generator control register bank
//
// Functional notes
// - force-shutter-clear bit at 1 holds shutter control logic in reset until cleared
// - timing-core run bit, active low: 0 holds core in reset, default 0
// - oscillator run bit, active low: 0 powers oscillator down, default 0
// - pending field-synchronous writes apply at the programmed line within the field
// - hold-field-updates bit at 1 blocks transfer of pending field-synchronous values
// - each transfer-pulse-pick bit marks its vertical drive output as gate pulse
// - mask override field sets per-output gate pulse masking when override enabled
// - override enable 0 uses field-register masking, 1 uses override field
// - wide line counter enable, default 1, selects 14-bit horizontal pixel counter
// - sync role select: 0 follower accepts syncs, 1 leader generates them
// - sync polarity: 0 active low, 1 active high, both syncs
// - line sync rise field sets horizontal sync rise pixel; minimum 36; a lower value is only flagged, not clamped
// - frame sync rise field in bits 25 to 13 sets vertical sync rise
package tgcr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_TEST_C      = 6'h10;
   localparam logic [5:0] IDX_SHUTTER     = 6'h13;
   localparam logic [5:0] IDX_CORE_RUN    = 6'h14;
   localparam logic [5:0] IDX_OSC_RUN     = 6'h15;
   localparam logic [5:0] IDX_TEST_A      = 6'h16;
   localparam logic [5:0] IDX_FIELD_UPD   = 6'h17;
   localparam logic [5:0] IDX_TEST_B      = 6'h18;
   localparam logic [5:0] IDX_TEST_D      = 6'h1a;
   localparam logic [5:0] IDX_TEST_E      = 6'h1b;
   localparam logic [5:0] IDX_PULSE_PICK  = 6'h1c;
   localparam logic [5:0] IDX_MASK_OVR    = 6'h1d;
   localparam logic [5:0] IDX_SPARE       = 6'h1e;
   localparam logic [5:0] IDX_WIDE_CNT    = 6'h1f;
   localparam logic [5:0] IDX_SYNC_ROLE   = 6'h20;
   localparam logic [5:0] IDX_SYNC_POL    = 6'h21;
   localparam logic [5:0] IDX_SYNC_EDGES  = 6'h22;
   localparam logic [5:0] IDX_STATUS      = 6'h3f;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int POS_SHUTTER_CLEAR  = 25;
   localparam int POS_HOLD_UPDATES   = 13;
   localparam int POS_MASK_OVR_EN    = 27;
   localparam int POS_FRAME_RISE_LO  = 13;
   localparam int POS_STATUS_PENDING = 16;
   localparam int LINE_W             = 13;
   localparam int TEST_W             = 28;
   localparam int PULSE_W            = 24;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [TEST_W-1:0] RST_TEST_A = 28'h0000001;
   localparam logic [TEST_W-1:0] RST_TEST_E = 28'h000000a;
   localparam logic              RST_WIDE   = 1'b1;
   localparam logic [12:0]       MIN_LINE_SYNC_RISE = 13'h0024;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic                force_shutter_clear;
      logic                timing_core_run_n;
      logic                oscillator_run_n;
      logic [TEST_W-1:0]   test_a;
      logic [TEST_W-1:0]   test_b;
      logic [TEST_W-1:0]   test_c;
      logic [TEST_W-1:0]   test_d;
      logic [TEST_W-1:0]   test_e;
      logic [LINE_W-1:0]   update_line;
      logic                hold_field_updates;
      logic [PULSE_W-1:0]  transfer_pulse_pick;
      logic [PULSE_W-1:0]  transfer_pulse_mask_override;
      logic                mask_override_enable;
      logic                wide_line_counter_enable;
      logic                sync_leader;
   } tgcr_imm_type;

   typedef struct packed {
      logic                sync_polarity;
      logic [LINE_W-1:0]   frame_sync_rise;
      logic [LINE_W-1:0]   line_sync_rise;
   } tgcr_sync_type;

   typedef struct packed {
      tgcr_imm_type        imm;
      tgcr_sync_type       shadow;
      tgcr_sync_type       active;
      logic                pending;
      logic [LINE_W-1:0]   line_count;
      logic [31:0]         prdata;
   } tgcr_state_type;

   localparam tgcr_state_type STATE_RESET = '{
      imm: '{test_a: RST_TEST_A, test_e: RST_TEST_E,
             wide_line_counter_enable: RST_WIDE, default: '0},
      default: '0};

endpackage : tgcr_pkg

/* src/tgcr_regs.sv */
// control register bank of the timing generator, apb slave
`timescale 1ns/10ps
`default_nettype none

module tgcr_regs
   import tgcr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   // apb slave
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [ADDR_W-1:0]   i_paddr,
   input  wire logic [31:0]         i_pwdata,
   input  wire logic [3:0]          i_pstrb,
   output logic                     o_pready,
   output logic                     o_pslverr,
   output logic [31:0]              o_prdata,
   // timing core events, same clock domain, one-cycle pulses
   input  wire logic                i_field_start,
   input  wire logic                i_line_start,
   input  wire logic [PULSE_W-1:0]  i_field_gate_mask,
   // controls to the timing core
   output logic                     o_shutter_reset,
   output logic                     o_timing_core_reset,
   output logic                     o_oscillator_power_down,
   output logic [PULSE_W-1:0]       o_transfer_pulse_pick,
   output logic [PULSE_W-1:0]       o_gate_pulse_mask,
   output logic                     o_wide_line_counter_enable,
   output logic                     o_sync_leader,
   output logic                     o_sync_polarity,
   output logic [LINE_W-1:0]        o_line_sync_rise,
   output logic [LINE_W-1:0]        o_frame_sync_rise,
   output logic                     o_line_sync_rise_low
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic idx_mapped(input logic [5:0] idx);
      case (idx)
         IDX_TEST_C, IDX_SHUTTER, IDX_CORE_RUN, IDX_OSC_RUN, IDX_TEST_A,
         IDX_FIELD_UPD, IDX_TEST_B, IDX_TEST_D, IDX_TEST_E, IDX_PULSE_PICK,
         IDX_MASK_OVR, IDX_SPARE, IDX_WIDE_CNT, IDX_SYNC_ROLE, IDX_SYNC_POL,
         IDX_SYNC_EDGES, IDX_STATUS: begin
            idx_mapped = 1'b1;
         end
         default: begin
            idx_mapped = 1'b0;
         end
      endcase
   endfunction : idx_mapped

   function automatic logic [31:0] read_word(input logic [5:0] idx,
                                             input tgcr_state_type s);
      read_word = 32'h0;
      case (idx)
         IDX_TEST_C:     read_word[TEST_W-1:0] = s.imm.test_c;
         IDX_SHUTTER:    read_word[POS_SHUTTER_CLEAR] = s.imm.force_shutter_clear;
         IDX_CORE_RUN:   read_word[0] = s.imm.timing_core_run_n;
         IDX_OSC_RUN:    read_word[0] = s.imm.oscillator_run_n;
         IDX_TEST_A:     read_word[TEST_W-1:0] = s.imm.test_a;
         IDX_FIELD_UPD: begin
            read_word[LINE_W-1:0] = s.imm.update_line;
            read_word[POS_HOLD_UPDATES] = s.imm.hold_field_updates;
         end
         IDX_TEST_B:     read_word[TEST_W-1:0] = s.imm.test_b;
         IDX_TEST_D:     read_word[TEST_W-1:0] = s.imm.test_d;
         IDX_TEST_E:     read_word[TEST_W-1:0] = s.imm.test_e;
         IDX_PULSE_PICK: read_word[PULSE_W-1:0] = s.imm.transfer_pulse_pick;
         IDX_MASK_OVR: begin
            read_word[PULSE_W-1:0] = s.imm.transfer_pulse_mask_override;
            read_word[POS_MASK_OVR_EN] = s.imm.mask_override_enable;
         end
         IDX_WIDE_CNT:   read_word[0] = s.imm.wide_line_counter_enable;
         IDX_SYNC_ROLE:  read_word[0] = s.imm.sync_leader;
         // field-synchronous words read back the latest written value
         IDX_SYNC_POL:   read_word[0] = s.shadow.sync_polarity;
         IDX_SYNC_EDGES: begin
            read_word[LINE_W-1:0] = s.shadow.line_sync_rise;
            read_word[POS_FRAME_RISE_LO +: LINE_W] = s.shadow.frame_sync_rise;
         end
         IDX_STATUS: begin
            read_word[LINE_W-1:0] = s.line_count;
            read_word[POS_STATUS_PENDING] = s.pending;
         end
         default: read_word = 32'h0;
      endcase
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////////
   // state

   tgcr_state_type state_reg;
   tgcr_state_type state_next;

   logic [5:0]        bus_idx;
   logic [ADDR_W+7:0] addr_ext;
   logic              bus_aligned;
   logic              bus_ok;
   logic              wr_fire;
   logic [31:0]       wdata;
   logic [LINE_W-1:0] cur_line;
   logic              apply_now;

   assign bus_idx     = i_paddr[7:2];
   // zero padding keeps the upper-bit check legal at the minimum address width
   assign addr_ext    = {8'h00, i_paddr};
   assign bus_aligned = (i_paddr[1:0] == 2'h0) && (addr_ext[ADDR_W+7:8] == '0);
   assign bus_ok      = bus_aligned && idx_mapped(bus_idx);
   assign wr_fire     = i_psel && i_penable && i_pwrite && bus_ok;

   // byte strobes merge new data over the current word
   always_comb begin
      wdata = read_word(bus_idx, state_reg);
      for (int b = 0; b < 4; b++) begin
         if (i_pstrb[b]) begin
            wdata[b*8 +: 8] = i_pwdata[b*8 +: 8];
         end
      end
   end

   // a line start coinciding with a field start counts as line zero
   assign cur_line  = i_field_start ? '0 : state_reg.line_count;
   assign apply_now = i_line_start && (cur_line == state_reg.imm.update_line)
                      && state_reg.pending && !state_reg.imm.hold_field_updates;

   always_comb begin
      state_next = state_reg;

      // line position within the field
      if (i_line_start) begin
         state_next.line_count = (cur_line == {LINE_W{1'b1}}) ? cur_line
                                 : cur_line + 13'h0001;
      end else begin
         state_next.line_count = cur_line;
      end

      // field-synchronous transfer; a write in the same cycle re-arms pending
      if (apply_now) begin
         state_next.active  = state_reg.shadow;
         state_next.pending = 1'b0;
      end

      // read data captured in the setup phase, held through access
      if (i_psel && !i_penable && !i_pwrite) begin
         state_next.prdata = bus_ok ? read_word(bus_idx, state_reg) : 32'h0;
      end

      if (wr_fire) begin
         case (bus_idx)
            IDX_TEST_C:    state_next.imm.test_c = wdata[TEST_W-1:0];
            IDX_SHUTTER:   state_next.imm.force_shutter_clear = wdata[POS_SHUTTER_CLEAR];
            IDX_CORE_RUN:  state_next.imm.timing_core_run_n = wdata[0];
            IDX_OSC_RUN:   state_next.imm.oscillator_run_n = wdata[0];
            IDX_TEST_A:    state_next.imm.test_a = wdata[TEST_W-1:0];
            IDX_FIELD_UPD: begin
               state_next.imm.update_line = wdata[LINE_W-1:0];
               state_next.imm.hold_field_updates = wdata[POS_HOLD_UPDATES];
            end
            IDX_TEST_B:    state_next.imm.test_b = wdata[TEST_W-1:0];
            IDX_TEST_D:    state_next.imm.test_d = wdata[TEST_W-1:0];
            IDX_TEST_E:    state_next.imm.test_e = wdata[TEST_W-1:0];
            IDX_PULSE_PICK: state_next.imm.transfer_pulse_pick = wdata[PULSE_W-1:0];
            IDX_MASK_OVR: begin
               state_next.imm.transfer_pulse_mask_override = wdata[PULSE_W-1:0];
               state_next.imm.mask_override_enable = wdata[POS_MASK_OVR_EN];
            end
            IDX_WIDE_CNT:  state_next.imm.wide_line_counter_enable = wdata[0];
            IDX_SYNC_ROLE: state_next.imm.sync_leader = wdata[0];
            IDX_SYNC_POL: begin
               state_next.shadow.sync_polarity = wdata[0];
               state_next.pending = 1'b1;
            end
            IDX_SYNC_EDGES: begin
               state_next.shadow.line_sync_rise = wdata[LINE_W-1:0];
               state_next.shadow.frame_sync_rise =
                  wdata[POS_FRAME_RISE_LO +: LINE_W];
               state_next.pending = 1'b1;
            end
            // spare word and status ignore writes
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // zero wait states: read data captured in the setup phase is ready in the access phase
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !bus_ok;
   assign o_prdata  = state_reg.prdata;

   assign o_shutter_reset            = state_reg.imm.force_shutter_clear;
   assign o_timing_core_reset        = !state_reg.imm.timing_core_run_n;
   assign o_oscillator_power_down    = !state_reg.imm.oscillator_run_n;
   assign o_transfer_pulse_pick      = state_reg.imm.transfer_pulse_pick;
   assign o_wide_line_counter_enable = state_reg.imm.wide_line_counter_enable;
   assign o_sync_leader              = state_reg.imm.sync_leader;
   assign o_sync_polarity            = state_reg.active.sync_polarity;
   assign o_line_sync_rise           = state_reg.active.line_sync_rise;
   assign o_frame_sync_rise          = state_reg.active.frame_sync_rise;
   // flag only; a value under the minimum is passed on, not clamped
   assign o_line_sync_rise_low = state_reg.active.line_sync_rise < MIN_LINE_SYNC_RISE;

   // one enable selects override field or field registers for all outputs
   generate
      for (genvar g = 0; g < PULSE_W; g++) begin : g_mask
         assign o_gate_pulse_mask[g] = state_reg.imm.mask_override_enable
            ? state_reg.imm.transfer_pulse_mask_override[g]
            : i_field_gate_mask[g];
      end
   endgenerate

endmodule : tgcr_regs

`default_nettype wire

/* verif/tgcr_regs_props.sv */
// assertion checker for the timing generator control register bank
`timescale 1ns/10ps
`default_nettype none
module tgcr_regs_props
   import tgcr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic               i_sys_clk,
   input wire logic               i_rst,
   // apb slave
   input wire logic               i_psel,
   input wire logic               i_penable,
   input wire logic               i_pwrite,
   input wire logic [ADDR_W-1:0]  i_paddr,
   input wire logic [31:0]        i_pwdata,
   input wire logic [3:0]         i_pstrb,
   input wire logic               o_pready,
   input wire logic               o_pslverr,
   input wire logic [31:0]        o_prdata,
   // timing core events
   input wire logic               i_field_start,
   input wire logic               i_line_start,
   input wire logic [PULSE_W-1:0] i_field_gate_mask,
   // controls to the timing core
   input wire logic               o_shutter_reset,
   input wire logic               o_timing_core_reset,
   input wire logic               o_oscillator_power_down,
   input wire logic [PULSE_W-1:0] o_transfer_pulse_pick,
   input wire logic [PULSE_W-1:0] o_gate_pulse_mask,
   input wire logic               o_wide_line_counter_enable,
   input wire logic               o_sync_leader,
   input wire logic               o_sync_polarity,
   input wire logic [LINE_W-1:0]  o_line_sync_rise,
   input wire logic [LINE_W-1:0]  o_frame_sync_rise,
   input wire logic               o_line_sync_rise_low
);
   logic       wr;
   logic [5:0] idx;
   assign wr  = i_psel & i_penable & i_pwrite & (i_paddr[1:0] == 2'h0);
   assign idx = i_paddr[7:2];
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////
   chk_shutter_write: assert property (wr && idx == IDX_SHUTTER && i_pstrb[3] |=>
      o_shutter_reset == $past(i_pwdata[25])) else $error("shutter reset wrong");
   chk_core_run_low: assert property (wr && idx == IDX_CORE_RUN && i_pstrb[0] |=>
      o_timing_core_reset == !$past(i_pwdata[0])) else $error("core reset wrong");
   chk_osc_run_low: assert property (wr && idx == IDX_OSC_RUN && i_pstrb[0] |=>
      o_oscillator_power_down == !$past(i_pwdata[0])) else $error("osc power wrong");
   chk_pick_write: assert property (wr && idx == IDX_PULSE_PICK && i_pstrb[2:0] == 3'h7 |=>
      o_transfer_pulse_pick == $past(i_pwdata[23:0])) else $error("pulse pick wrong");
   chk_override_on: assert property (wr && idx == IDX_MASK_OVR && i_pstrb == 4'hf
      && i_pwdata[27] |=> o_gate_pulse_mask == $past(i_pwdata[23:0])) else $error("override wrong");
   chk_override_off: assert property (wr && idx == IDX_MASK_OVR && i_pstrb[3]
      && !i_pwdata[27] |=> o_gate_pulse_mask == i_field_gate_mask) else $error("field mask wrong");
   chk_wide_write: assert property (wr && idx == IDX_WIDE_CNT && i_pstrb[0] |=>
      o_wide_line_counter_enable == $past(i_pwdata[0])) else $error("wide counter wrong");
   chk_leader_write: assert property (wr && idx == IDX_SYNC_ROLE && i_pstrb[0] |=>
      o_sync_leader == $past(i_pwdata[0])) else $error("sync role wrong");
   chk_rise_low_flag: assert property (
      o_line_sync_rise_low == (o_line_sync_rise < 13'h0024)) else $error("rise flag wrong");
   // field-synchronous copies may move only on the edge of a line start
   chk_sync_only_line: assert property (!$past(i_line_start) |->
      $stable({o_sync_polarity, o_line_sync_rise, o_frame_sync_rise})) else $error("sync moved");
   cover property (wr && idx == IDX_SYNC_EDGES);
   cover property ($changed(o_line_sync_rise));
   cover property (i_psel && i_penable && o_pslverr);
endmodule : tgcr_regs_props
bind tgcr_regs tgcr_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

/* verif/tgcr_regs_tb.sv */
// self-checking testbench for the timing generator control register bank
`timescale 1ns/10ps
`default_nettype none
module tgcr_regs_tb
   import tgcr_pkg::*;
();
   logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   logic        i_pwrite = 1'b0, i_field_start = 1'b0, i_line_start = 1'b0;
   logic [7:0]  i_paddr = 8'h00;
   logic [3:0]  i_pstrb = 4'h0;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd, a21 = 32'h0, a22 = 32'h0;
   logic [23:0] i_field_gate_mask = 24'h0, o_transfer_pulse_pick, o_gate_pulse_mask;
   logic        o_pready, o_pslverr, o_shutter_reset, o_timing_core_reset, er, pend = 1'b0;
   logic        o_oscillator_power_down, o_wide_line_counter_enable, o_sync_leader;
   logic        o_sync_polarity, o_line_sync_rise_low;
   logic [12:0] o_line_sync_rise, o_frame_sync_rise;
   logic [31:0] m [64];
   int          err_count = 0, checks = 0, seed = 50, cnt = 0;
   always #2.5 i_sys_clk = ~i_sys_clk;
   tgcr_regs uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
      .i_field_start(i_field_start), .i_line_start(i_line_start),
      .i_field_gate_mask(i_field_gate_mask), .o_shutter_reset(o_shutter_reset),
      .o_timing_core_reset(o_timing_core_reset), .o_sync_leader(o_sync_leader),
      .o_oscillator_power_down(o_oscillator_power_down), .o_sync_polarity(o_sync_polarity),
      .o_transfer_pulse_pick(o_transfer_pulse_pick), .o_gate_pulse_mask(o_gate_pulse_mask),
      .o_wide_line_counter_enable(o_wide_line_counter_enable), .o_line_sync_rise(o_line_sync_rise),
      .o_frame_sync_rise(o_frame_sync_rise), .o_line_sync_rise_low(o_line_sync_rise_low));
   ////////////////////////////////////////////////////////////////////////////
   // writable bits per index; bit 32 flags an unmapped index
   function automatic logic [32:0] msk(input logic [5:0] i);
      case (i)
         6'h10, 6'h16, 6'h18, 6'h1a, 6'h1b: msk = 33'h00fffffff;
         6'h13: msk = 33'h002000000;
         6'h14, 6'h15, 6'h1f, 6'h20, 6'h21: msk = 33'h000000001;
         6'h17: msk = 33'h000003fff;
         6'h1c: msk = 33'h000ffffff;
         6'h1d: msk = 33'h008ffffff;
         6'h1e: msk = 33'h000000000;
         6'h22: msk = 33'h003ffffff;
         6'h3f: msk = 33'h000000000;
         default: msk = 33'h100000000;
      endcase
   endfunction : msk
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // one apb transfer; the model follows every write that the slave accepts
   task automatic apb(input logic [5:0] i, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      int          n;
      logic [32:0] k;
      logic [31:0] bm;
      k = msk(i);
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= {i, 2'h0};
      i_pwdata <= d;
      i_pstrb <= s;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_count++;
         results();
      end
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      cmp(32'(er), 32'(k[32]));
      if (w && !k[32]) m[i] = ((m[i] & ~bm) | (d & bm)) & k[31:0];
      if (w && (i == 6'h21 || i == 6'h22)) pend = 1'b1;
      if (!w) cmp(rd, k[32] ? 32'h0 : m[i]);
   endtask : apb
   // one cycle of field and line start, with the transfer model beside it
   task automatic pulse(input logic fs, input logic ls);
      int cur;
      @(posedge i_sys_clk);
      i_field_start <= fs;
      i_line_start <= ls;
      @(posedge i_sys_clk);
      i_field_start <= 1'b0;
      i_line_start <= 1'b0;
      cur = fs ? 0 : cnt;
      if (ls && cur == m[6'h17][12:0] && pend && !m[6'h17][13]) begin
         a21 = m[6'h21];
         a22 = m[6'h22];
         pend = 1'b0;
      end
      cnt = (ls && cur < 8191) ? cur + 1 : cur;
   endtask : pulse
   task automatic outs();
      @(posedge i_sys_clk);
      #1;
      cmp(32'(o_timing_core_reset), 32'(!m[6'h14][0]));
      cmp(32'(o_oscillator_power_down), 32'(!m[6'h15][0]));
      cmp(32'(o_shutter_reset), 32'(m[6'h13][25]));
      cmp(32'(o_transfer_pulse_pick), m[6'h1c]);
      cmp(32'(o_gate_pulse_mask), m[6'h1d][27] ? m[6'h1d] & 32'hffffff : 32'(i_field_gate_mask));
      cmp(32'(o_wide_line_counter_enable), m[6'h1f]);
      cmp(32'(o_sync_leader), m[6'h20]);
      cmp(32'({o_sync_polarity, o_frame_sync_rise, o_line_sync_rise}), {a21[5:0], a22[25:0]});
      cmp(32'(o_line_sync_rise_low), 32'(a22[12:0] < 13'h0024));
   endtask : outs
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 64; i++) m[i] = 32'h0;
      m[6'h16] = 32'h1;
      m[6'h1b] = 32'ha;
      m[6'h1f] = 32'h1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (int i = 6'h10; i < 6'h23; i++) apb(6'(i), 1'b0, 32'h0, 4'h0);
      outs();
      $display("test reset values done");
      for (int r = 0; r < 10; r++) begin
         i_field_gate_mask <= 24'($random(seed));
         for (int i = 6'h11; i < 6'h23; i++)
            if (msk(6'(i)) != 33'h00fffffff && i != 6'h17 && i != 6'h1e)
               apb(6'(i), 1'b1, $random(seed), 4'($random(seed)));
         apb(6'h1e, 1'b1, 32'h0, 4'hf);
         apb(6'h16, 1'b1, 32'h1, 4'hf);
         apb(6'h1b, 1'b1, 32'ha, 4'hf);
         outs();
         for (int i = 6'h10; i < 6'h23; i++) apb(6'(i), 1'b0, 32'h0, 4'h0);
      end
      $display("test random access done");
      apb(6'h17, 1'b1, 32'h3, 4'hf);
      apb(6'h22, 1'b1, {6'h0, 13'h0100, 13'h0014}, 4'hf);
      apb(6'h21, 1'b1, 32'h1, 4'hf);
      pulse(1'b1, 1'b0);
      for (int k = 0; k < 5; k++) begin
         pulse(1'b0, 1'b1);
         outs();
      end
      apb(6'h17, 1'b1, 32'h2000, 4'hf);
      apb(6'h22, 1'b1, {6'h0, 13'h1fff, 13'h0024}, 4'hf);
      pulse(1'b1, 1'b1);
      outs();
      // status word: line position and the pending flag that hold keeps set
      m[6'h3f] = {15'h0, pend, 3'h0, 13'(cnt)};
      apb(6'h3f, 1'b0, 32'h0, 4'h0);
      apb(6'h17, 1'b1, 32'h0, 4'hf);
      pulse(1'b1, 1'b1);
      outs();
      m[6'h3f] = {15'h0, pend, 3'h0, 13'(cnt)};
      apb(6'h3f, 1'b0, 32'h0, 4'h0);
      $display("test field update done");
      results();
   end
endmodule : tgcr_regs_tb
`default_nettype wire
